// ---- rtl/rstc_pkg.sv ----
package rstc_pkg;
    localparam int          CLK_HZ          = 40_000_000;
    // Time base of one stamp count, in microseconds
    localparam int          TICK_US         = 50;
    localparam int          TICK_CYCLES     = (CLK_HZ / 1_000_000) * TICK_US;
    localparam logic [11:0] TICK_LAST       = 12'(TICK_CYCLES - 1);
    localparam logic [7:0]  ADDR_HIGH_CH5   = 8'h98;
    localparam logic [7:0]  ADDR_LOW_CH5    = 8'h99;
    localparam logic [7:0]  ADDR_HIGH_CH6   = 8'h9A;
    localparam logic [7:0]  ADDR_LOW_CH6    = 8'h9B;
    localparam logic [15:0] STAMP_RESET     = 16'h0000;
    localparam logic [1:0]  CODE_RISE       = 2'h1;
    localparam logic [1:0]  CODE_FALL       = 2'h2;
    localparam int          NUM_CH          = 2;
    typedef enum logic [1:0] {
        RSTC_IDLE,
        RSTC_RISE,
        RSTC_FALL
    } rstc_mode_t;
endpackage

// ---- rtl/rstc_capture.sv ----
`timescale 1ns/1ps
// Behaviour
// - Upper stamp byte of each channel is one read-only 8-bit field.
// - Lower stamp byte is a separate read-only register paired with the upper.
// - Stamp value assigned during sequences launched by active or sleep control.
// - Code 01 sequences latch on rising crossing of the low undervoltage threshold.
// - Code 10 sequences latch on falling crossing of the 200mV off threshold.
// - One stamp count equals 50 microseconds of sequence time.
// - High byte at even address, low byte next; ch5 at 98h, ch6 at 9Ah.
module rstc_capture (
    input  wire logic       CLK_IN,          // 40 MHz clock
    input  wire logic       NRST_IN,         // Async reset, active low
    input  wire logic       SEQ_START_IN,    // One-cycle pulse: sequence triggered
    input  wire logic [1:0] ACTIVE_SEQUENCE_CONTROL_IN, // Active-mode control code
    input  wire logic [1:0] SLEEP_CODE_IN,   // Sleep control code
    input  wire logic       SLEEP_SEL_IN,    // High: sleep field launched sequence
    input  wire logic [1:0] UV_RISE_IN,      // Rising past low UV threshold, ch6..ch5
    input  wire logic [1:0] OFF_FALL_IN,     // Falling below off threshold, ch6..ch5
    input  wire logic       RD_EN_IN,        // Register read strobe
    input  wire logic [7:0] RD_ADDR_IN,      // Register address
    output logic      [7:0] RD_DATA_OUT,     // Read data, registered
    output logic            RD_VALID_OUT,    // Read data valid pulse
    output logic      [1:0] CAPTURED_OUT     // Channel captured this sequence
);

    typedef struct packed {
        rstc_pkg::rstc_mode_t mode;
        logic [11:0]          div;
        logic [15:0]          stamp_timer;
        logic [1:0][15:0]     stamp;
        logic [1:0]           captured;
        logic [7:0]           rd_data;
        logic                 rd_valid;
    } rstc_state_t;

    rstc_state_t st;
    rstc_state_t next_st;
    logic [1:0]  code;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.rd_valid = 1'b0;
        code = SLEEP_SEL_IN ? SLEEP_CODE_IN : ACTIVE_SEQUENCE_CONTROL_IN;
        if (SEQ_START_IN) begin
            next_st.div         = 12'h000;
            next_st.stamp_timer = 16'h0000;
            next_st.captured    = 2'h0;
            unique case (code)
                rstc_pkg::CODE_RISE: next_st.mode = rstc_pkg::RSTC_RISE;
                rstc_pkg::CODE_FALL: next_st.mode = rstc_pkg::RSTC_FALL;
                default:             next_st.mode = rstc_pkg::RSTC_IDLE;
            endcase
        end else if (st.mode != rstc_pkg::RSTC_IDLE) begin
            if (st.div == rstc_pkg::TICK_LAST) begin
                next_st.div = 12'h000;
                if (st.stamp_timer != 16'hFFFF) begin
                    next_st.stamp_timer = st.stamp_timer + 16'h0001;
                end
            end else begin
                next_st.div = st.div + 12'h001;
            end
            for (int i = 0; i < rstc_pkg::NUM_CH; i++) begin
                if (!st.captured[i] &&
                    ((st.mode == rstc_pkg::RSTC_RISE && UV_RISE_IN[i]) ||
                     (st.mode == rstc_pkg::RSTC_FALL && OFF_FALL_IN[i]))) begin
                    next_st.stamp[i]    = st.stamp_timer;
                    next_st.captured[i] = 1'b1;
                end
            end
        end
        if (RD_EN_IN) begin
            next_st.rd_valid = 1'b1;
            unique case (RD_ADDR_IN)
                rstc_pkg::ADDR_HIGH_CH5: next_st.rd_data = st.stamp[0][15:8];
                rstc_pkg::ADDR_LOW_CH5:  next_st.rd_data = st.stamp[0][7:0];
                rstc_pkg::ADDR_HIGH_CH6: next_st.rd_data = st.stamp[1][15:8];
                rstc_pkg::ADDR_LOW_CH6:  next_st.rd_data = st.stamp[1][7:0];
                default:                 next_st.rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            st.mode        <= rstc_pkg::RSTC_IDLE;
            st.div         <= 12'h000;
            st.stamp_timer <= 16'h0000;
            st.stamp       <= {rstc_pkg::STAMP_RESET, rstc_pkg::STAMP_RESET};
            st.captured    <= 2'h0;
            st.rd_data     <= 8'h00;
            st.rd_valid    <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign RD_DATA_OUT  = st.rd_data;
    assign RD_VALID_OUT = st.rd_valid;
    assign CAPTURED_OUT = st.captured;

    ////////////////////////////////////////////////////////////////////////////
    property p_restart;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        SEQ_START_IN |=> (st.stamp_timer == 16'h0000 && st.div == 12'h000);
    endproperty
    a_restart: assert property (p_restart) else $error("timer not restarted");

    property p_tick;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (st.mode != rstc_pkg::RSTC_IDLE && !SEQ_START_IN && st.div == rstc_pkg::TICK_LAST
         && st.stamp_timer != 16'hFFFF)
        |=> st.stamp_timer == $past(st.stamp_timer) + 16'h0001;
    endproperty
    a_tick: assert property (p_tick) else $error("tick did not advance stamp");

    property p_hold;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (st.div != rstc_pkg::TICK_LAST && !SEQ_START_IN) |=> $stable(st.stamp_timer);
    endproperty
    a_hold: assert property (p_hold) else $error("stamp moved between ticks");

    property p_rise;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (st.mode == rstc_pkg::RSTC_RISE && !SEQ_START_IN && UV_RISE_IN[0] && !st.captured[0])
        |=> (st.stamp[0] == $past(st.stamp_timer) && st.captured[0]);
    endproperty
    a_rise: assert property (p_rise) else $error("ch5 rise not captured");

    property p_fall;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (st.mode == rstc_pkg::RSTC_FALL && !SEQ_START_IN && OFF_FALL_IN[1] && !st.captured[1])
        |=> (st.stamp[1] == $past(st.stamp_timer) && st.captured[1]);
    endproperty
    a_fall: assert property (p_fall) else $error("ch6 fall not captured");

    property p_mode;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (SEQ_START_IN && code == rstc_pkg::CODE_FALL) |=> st.mode == rstc_pkg::RSTC_FALL;
    endproperty
    a_mode: assert property (p_mode) else $error("wrong sequence mode");

    property p_rd_high;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (RD_EN_IN && RD_ADDR_IN == rstc_pkg::ADDR_HIGH_CH6)
        |=> (RD_VALID_OUT && RD_DATA_OUT == $past(st.stamp[1][15:8]));
    endproperty
    a_rd_high: assert property (p_rd_high) else $error("bad high byte read");

    property p_rd_low;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (RD_EN_IN && RD_ADDR_IN == rstc_pkg::ADDR_LOW_CH5)
        |=> (RD_VALID_OUT && RD_DATA_OUT == $past(st.stamp[0][7:0]));
    endproperty
    a_rd_low: assert property (p_rd_low) else $error("bad low byte read");

    property p_map;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (RD_EN_IN && RD_ADDR_IN == rstc_pkg::ADDR_LOW_CH6)
        |=> RD_DATA_OUT == $past(st.stamp[1][7:0]);
    endproperty
    a_map: assert property (p_map) else $error("bad map at ch6 low");

    property p_rd_high5;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (RD_EN_IN && RD_ADDR_IN == rstc_pkg::ADDR_HIGH_CH5)
        |=> (RD_VALID_OUT && RD_DATA_OUT == $past(st.stamp[0][15:8]));
    endproperty
    a_rd_high5: assert property (p_rd_high5) else $error("bad ch5 high byte read");

    property p_rise6;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (st.mode == rstc_pkg::RSTC_RISE && !SEQ_START_IN && UV_RISE_IN[1] && !st.captured[1])
        |=> (st.stamp[1] == $past(st.stamp_timer) && st.captured[1]);
    endproperty
    a_rise6: assert property (p_rise6) else $error("ch6 rise not captured");

    property p_fall5;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (st.mode == rstc_pkg::RSTC_FALL && !SEQ_START_IN && OFF_FALL_IN[0] && !st.captured[0])
        |=> (st.stamp[0] == $past(st.stamp_timer) && st.captured[0]);
    endproperty
    a_fall5: assert property (p_fall5) else $error("ch5 fall not captured");

    property p_mode_rise;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (SEQ_START_IN && code == rstc_pkg::CODE_RISE) |=> st.mode == rstc_pkg::RSTC_RISE;
    endproperty
    a_mode_rise: assert property (p_mode_rise) else $error("rise mode not entered");

    // Codes other than rise and fall leave the block idle
    property p_mode_idle;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (SEQ_START_IN && code != rstc_pkg::CODE_RISE && code != rstc_pkg::CODE_FALL)
        |=> st.mode == rstc_pkg::RSTC_IDLE;
    endproperty
    a_mode_idle: assert property (p_mode_idle) else $error("idle mode not entered");

    property p_cap_clear;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        SEQ_START_IN |=> CAPTURED_OUT == 2'h0;
    endproperty
    a_cap_clear: assert property (p_cap_clear) else $error("captured not cleared");

    // Idle never touches the stamps, whatever the rails do
    property p_idle_keep;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (st.mode == rstc_pkg::RSTC_IDLE && !SEQ_START_IN)
        |=> ($stable(st.stamp) && $stable(st.captured));
    endproperty
    a_idle_keep: assert property (p_idle_keep) else $error("stamp moved while idle");

    // First crossing only; a bouncing rail cannot overwrite the stamp
    property p_first5;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (st.captured[0] && !SEQ_START_IN) |=> $stable(st.stamp[0]);
    endproperty
    a_first5: assert property (p_first5) else $error("ch5 stamp overwritten");

    property p_first6;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (st.captured[1] && !SEQ_START_IN) |=> $stable(st.stamp[1]);
    endproperty
    a_first6: assert property (p_first6) else $error("ch6 stamp overwritten");

    property p_wrong_dir;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (st.mode == rstc_pkg::RSTC_RISE && !SEQ_START_IN && !UV_RISE_IN[1])
        |=> $stable(st.stamp[1]);
    endproperty
    a_wrong_dir: assert property (p_wrong_dir) else $error("ch6 stamp without rise");

    property p_div_step;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (st.mode != rstc_pkg::RSTC_IDLE && !SEQ_START_IN && st.div != rstc_pkg::TICK_LAST)
        |=> st.div == $past(st.div) + 12'h001;
    endproperty
    a_div_step: assert property (p_div_step) else $error("divider did not step");

    property p_div_wrap;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (st.mode != rstc_pkg::RSTC_IDLE && !SEQ_START_IN && st.div == rstc_pkg::TICK_LAST)
        |=> st.div == 12'h000;
    endproperty
    a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap");

    property p_rd_valid;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        RD_EN_IN |=> RD_VALID_OUT;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");

    property p_rd_pulse;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        !RD_EN_IN |=> !RD_VALID_OUT;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("valid without read");

    // Addresses outside the two pairs answer with zero
    property p_rd_unmapped;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (RD_EN_IN &&
         (RD_ADDR_IN < rstc_pkg::ADDR_HIGH_CH5 || RD_ADDR_IN > rstc_pkg::ADDR_LOW_CH6))
        |=> RD_DATA_OUT == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_rd_keep;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        !RD_EN_IN |=> $stable(RD_DATA_OUT);
    endproperty
    a_rd_keep: assert property (p_rd_keep) else $error("read data changed idle");

endmodule

// ---- sim/rstc_rail_model.sv ----
`timescale 1ns/1ps
module rstc_rail_model (
    input  wire logic        clk_in,       // Bench clock
    input  wire logic        nrst_in,      // Async reset, active low
    input  wire logic        on_in,        // Target: high means powered
    input  wire logic [15:0] ramp_in,      // Ramp time in cycles
    output logic             uv_rise_out,  // Rail above low UV threshold
    output logic             off_fall_out  // Rail below off threshold
);
    logic        level;
    logic [15:0] cnt;
    // A rail never sits in both states, so the two flags stay complementary
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            level <= 1'b0;
            cnt   <= 16'h0000;
        end else if (on_in == level) begin
            cnt <= 16'h0000;
        end else if (cnt >= ramp_in) begin
            level <= on_in;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
    assign uv_rise_out  = level;
    assign off_fall_out = !level;
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module testbench;
    logic        clk, nrst, start, sel, rd_en, rd_valid;
    logic [1:0]  active_code, slp, uv, off, on, cap;
    logic [7:0]  addr, rd_data;
    logic [15:0] r5, r6;
    int          n_fail, num_checks;
    rstc_capture i_dut (.CLK_IN(clk), .NRST_IN(nrst), .SEQ_START_IN(start),
        .ACTIVE_SEQUENCE_CONTROL_IN(active_code), .SLEEP_CODE_IN(slp), .SLEEP_SEL_IN(sel),
        .UV_RISE_IN(uv), .OFF_FALL_IN(off), .RD_EN_IN(rd_en), .RD_ADDR_IN(addr),
        .RD_DATA_OUT(rd_data), .RD_VALID_OUT(rd_valid), .CAPTURED_OUT(cap));
    rstc_rail_model i_ch5 (.clk_in(clk), .nrst_in(nrst), .on_in(on[0]), .ramp_in(r5),
        .uv_rise_out(uv[0]), .off_fall_out(off[0]));
    rstc_rail_model i_ch6 (.clk_in(clk), .nrst_in(nrst), .on_in(on[1]), .ramp_in(r6),
        .uv_rise_out(uv[1]), .off_fall_out(off[1]));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = !clk;
    end
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        `CHK(rd_valid, 1'b1)
        `CHK(rd_data, e)
        // Valid is a one-cycle pulse; data stands until the next read
        @(posedge clk);
        #1;
        `CHK(rd_valid, 1'b0)
        `CHK(rd_data, e)
    endtask
    // Ramps sit mid-tick so a one-cycle skew cannot move the stamp
    task automatic seq(input logic s, input logic [1:0] c, input logic [1:0] tgt,
                       input logic [15:0] a5, input logic [15:0] a6, input int wait_n);
        @(posedge clk);
        start <= 1'b1;
        sel   <= s;
        active_code <= s ? 2'h0 : c;
        slp   <= s ? c : 2'h3;
        on    <= tgt;
        r5    <= a5;
        r6    <= a6;
        @(posedge clk);
        start <= 1'b0;
        repeat (wait_n) @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, start, sel, rd_en, active_code, slp, on, addr} = '0;
        r5 = 16'h0000;
        r6 = 16'h0000;
        n_fail = 0;
        num_checks = 0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(8'h98, 8'h00);
        rd(8'h9C, 8'h00);
        $display("test reset done");
        seq(1'b0, 2'h1, 2'h3, 16'h1B58, 16'h32C8, 14000);
        `CHK(cap, 2'h3)
        rd(8'h98, 8'h00);
        rd(8'h99, 8'h03);
        rd(8'h9A, 8'h00);
        rd(8'h9B, 8'h06);
        $display("test power-on done");
        // First trigger outlasts two ticks, so a timer not restarted shows
        seq(1'b1, 2'h2, 2'h0, 16'h32C8, 16'h32C8, 4000);
        seq(1'b1, 2'h2, 2'h0, 16'h1B58, 16'h2328, 6000);
        `CHK(cap, 2'h3)
        rd(8'h99, 8'h01);
        rd(8'h9B, 8'h02);
        $display("test sleep-entry done");
        seq(1'b1, 2'h1, 2'h3, 16'h1388, 16'h0BB8, 8000);
        `CHK(cap, 2'h3)
        rd(8'h99, 8'h02);
        rd(8'h9B, 8'h01);
        $display("test sleep-exit done");
        seq(1'b0, 2'h2, 2'h0, 16'h0BB8, 16'h1B58, 8000);
        `CHK(cap, 2'h3)
        rd(8'h99, 8'h01);
        rd(8'h9B, 8'h03);
        $display("test power-off done");
        seq(1'b0, 2'h0, 2'h3, 16'h0064, 16'h0064, 500);
        `CHK(cap, 2'h0)
        seq(1'b1, 2'h3, 2'h0, 16'h0064, 16'h0064, 500);
        `CHK(cap, 2'h0)
        rd(8'h99, 8'h01);
        rd(8'h9B, 8'h03);
        $display("test idle done");
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(8'h99, 8'h00);
        rd(8'h9B, 8'h00);
        `CHK(cap, 2'h0)
        $display("test mid-run reset done");
        give_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
endmodule
